// ===== design/flecc_row.sv
// one row of logic element groups with carry chain, configured over apb
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1: element flip-flop acts as d, toggle, jk or set-reset register by config.
// R2: clock, clear and preset each pick dedicated, global, pin or internal logic source.
// R3: combinatorial setting bypasses flip-flop, lookup result drives element output.
// R4: local and row outputs each choose lookup result or register independently.
// R5: carry from lower bit feeds this lookup table and the next chain stage.
// R6: chains longer than eight elements continue by linking groups together.
// R7: group links skip alternate groups, even to even and odd to odd.
// R8: chain never crosses the mid-row memory block; halves hold separate chains.
// R9: two dedicated inputs reach controls directly; four drive globals, internal logic may instead.
// R10: lookup table is a four-input function set by its sixteen-bit truth table.
module flecc_row
  import flecc_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // control pins
  input wire logic [DEDICATED-1:0] dedicated_in,
  input wire logic [GP_PINS-1:0] gp_pin,
  // element data
  input wire flecc_le_in_t le_in [0:LES-1],
  output flecc_le_out_t le_out [0:LES-1],
  output logic [1:0] chain_carry_out
);

  function automatic logic flecc_lut(input logic [15:0] table_bits, input logic [3:0] sel);
    return table_bits[sel];
  endfunction : flecc_lut

  function automatic logic flecc_src(input logic [3:0] sel, input logic [GLOBALS-1:0] glob,
                                     input logic [GP_PINS-1:0] pins, input logic [DEDICATED-1:0] ded,
                                     input logic [3:0] internal);
    logic v;
    v = 1'b0;
    case (sel[3:2])
      SRC_DEDICATED: v = ded[4 + {1'b0, sel[0]}];
      SRC_GLOBAL: v = glob[sel[1:0]];
      SRC_PIN: v = pins[sel[1:0]];
      SRC_INTERNAL: v = internal[sel[1:0]];
      default: v = 1'b0;
    endcase
    return v;
  endfunction : flecc_src

  // configuration and bus state
  logic [31:0] cfg [0:LES-1];
  logic [31:0] next_cfg [0:LES-1];
  logic [31:0] chain_cfg, next_chain_cfg;
  logic [31:0] gsrc_cfg, next_gsrc_cfg;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  // element state
  logic [LES-1:0] ff_q, next_ff_q;
  logic [LES-1:0] clk_prev, next_clk_prev;
  flecc_le_out_t next_le_out [0:LES-1];
  logic [1:0] next_chain_carry_out;
  // combinational element values
  logic [LES-1:0] lut_val, carry_val, local_val;
  logic [GLOBALS-1:0] glob;

  always_comb begin
    logic access, done, mapped;
    logic [31:0] rd;
    access = psel & penable;
    done = access & pready;
    mapped = 1'b1;
    rd = 32'h0000_0000;
    next_cfg = cfg;
    next_chain_cfg = chain_cfg;
    next_gsrc_cfg = gsrc_cfg;
    if (paddr[11:8] == CFG_BASE[11:8]) begin
      rd = cfg[paddr[7:2]];
    end else begin
      case (paddr)
        CHAIN_ADDR: rd = chain_cfg;
        GSRC_ADDR: rd = gsrc_cfg;
        STATE_LO_ADDR: rd = ff_q[31:0];
        STATE_HI_ADDR: rd = ff_q[63:32];
        default: mapped = 1'b0;
      endcase
    end
    // one wait state so the answer leaves a flop
    next_pready = access & ~pready;
    next_prdata = (next_pready & ~pwrite & mapped) ? rd : 32'h0000_0000;
    next_pslverr = next_pready & ~mapped;
    if (done & pwrite & mapped) begin
      if (paddr[11:8] == CFG_BASE[11:8]) begin
        next_cfg[paddr[7:2]] = pwdata;
      end else if (paddr == CHAIN_ADDR) begin
        next_chain_cfg = pwdata;
      end else if (paddr == GSRC_ADDR) begin
        next_gsrc_cfg = pwdata;
      end
    end
  end

  always_comb begin
    logic cin;
    int e;
    int lower;
    cin = 1'b0;
    e = 0;
    lower = 0;
    lut_val = '0;
    carry_val = '0;
    for (int g = 0; g < GROUPS; g++) begin
      for (int k = 0; k < LES_PER_GROUP; k++) begin
        e = g * LES_PER_GROUP + k;
        if (k != 0) begin
          // R5: carry from lower bit
          cin = carry_val[e-1];
        // R8: no link across memory block
        end else if (chain_cfg[LINK_LSB + g] && (g % HALF_GROUPS) >= 2) begin
          // R6: link groups; R7: skip alternate group
          lower = (g - 2) * LES_PER_GROUP + LES_PER_GROUP - 1;
          cin = carry_val[lower];
        end else begin
          cin = chain_cfg[CARRY_INIT_LSB + g];
        end
        if (chain_cfg[CARRY_MODE_LSB + g]) begin
          // R5: carry feeds lookup and next stage
          lut_val[e] = flecc_lut(cfg[e][15:0], {1'b0, le_in[e].a, le_in[e].b, cin});
          carry_val[e] = flecc_lut(cfg[e][15:0], {1'b1, le_in[e].a, le_in[e].b, cin});
        end else begin
          // R10: four-input truth table
          lut_val[e] = flecc_lut(cfg[e][LUT_LSB +: 16], {le_in[e].a, le_in[e].b, le_in[e].c, le_in[e].d});
          carry_val[e] = cin;
        end
      end
    end
  end

  always_comb begin
    logic [GSRC_IDX_W-1:0] idx;
    idx = '0;
    local_val = '0;
    glob = '0;
    for (int e = 0; e < LES; e++) begin
      // R3: bypass the flip-flop
      local_val[e] = cfg[e][BYP_LOCAL_BIT] ? lut_val[e] : ff_q[e];
    end
    for (int i = 0; i < GLOBALS; i++) begin
      idx = gsrc_cfg[i*8 +: GSRC_IDX_W];
      // R9: global from pin or internal
      glob[i] = gsrc_cfg[i*8 + GSRC_INT_BIT] ? local_val[idx] : dedicated_in[i];
    end
  end

  // element clocks are sampled on pclk; a rising edge of the chosen source steps the flop
  always_comb begin
    logic [3:0] internal;
    logic clk_now, clr, pre, fire, side_in;
    int base;
    internal = 4'h0;
    clk_now = 1'b0;
    clr = 1'b0;
    pre = 1'b0;
    fire = 1'b0;
    side_in = 1'b0;
    base = 0;
    next_ff_q = ff_q;
    next_clk_prev = clk_prev;
    for (int e = 0; e < LES; e++) begin
      base = (e / LES_PER_GROUP) * LES_PER_GROUP;
      internal = local_val[base +: 4];
      // R2: control source selection
      clk_now = flecc_src(cfg[e][CLK_SEL_LSB +: 4], glob, gp_pin, dedicated_in, internal);
      clr = flecc_src(cfg[e][CLR_SEL_LSB +: 4], glob, gp_pin, dedicated_in, internal);
      pre = flecc_src(cfg[e][PRE_SEL_LSB +: 4], glob, gp_pin, dedicated_in, internal);
      fire = clk_now & ~clk_prev[e];
      side_in = le_in[e].d;
      next_clk_prev[e] = clk_now;
      if (clr) begin
        next_ff_q[e] = 1'b0;
      end else if (pre) begin
        next_ff_q[e] = 1'b1;
      end else if (fire) begin
        // R1: register type
        case (flecc_ff_mode_t'(cfg[e][MODE_LSB +: 2]))
          FF_D: next_ff_q[e] = lut_val[e];
          FF_T: next_ff_q[e] = ff_q[e] ^ lut_val[e];
          FF_JK: next_ff_q[e] = (lut_val[e] & ~ff_q[e]) | (~side_in & ff_q[e]);
          FF_SR: next_ff_q[e] = lut_val[e] | (~side_in & ff_q[e]);
          default: next_ff_q[e] = ff_q[e];
        endcase
      end
    end
  end

  always_comb begin
    for (int e = 0; e < LES; e++) begin
      // R4: independent output sources
      next_le_out[e].local_out = cfg[e][BYP_LOCAL_BIT] ? lut_val[e] : ff_q[e];
      next_le_out[e].row_out = cfg[e][BYP_ROW_BIT] ? lut_val[e] : ff_q[e];
    end
    // R8: each half ends its own chain
    next_chain_carry_out[0] = carry_val[HALF_GROUPS * LES_PER_GROUP - 1];
    next_chain_carry_out[1] = carry_val[LES - 1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int e = 0; e < LES; e++) begin
        cfg[e] <= CFG_RESET;
        le_out[e] <= '0;
      end
      chain_cfg <= CHAIN_RESET;
      gsrc_cfg <= GSRC_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ff_q <= '0;
      clk_prev <= '0;
      chain_carry_out <= 2'h0;
    end else begin
      cfg <= next_cfg;
      le_out <= next_le_out;
      chain_cfg <= next_chain_cfg;
      gsrc_cfg <= next_gsrc_cfg;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      ff_q <= next_ff_q;
      clk_prev <= next_clk_prev;
      chain_carry_out <= next_chain_carry_out;
    end
  end
endmodule : flecc_row
`default_nettype wire

// ===== pkg/flecc_pkg.sv
// constants and types shared by the logic element row
package flecc_pkg;
  localparam int GROUPS = 8;
  localparam int LES_PER_GROUP = 8;
  localparam int LES = 64;
  localparam int HALF_GROUPS = 4;
  localparam int GLOBALS = 4;
  localparam int DEDICATED = 6;
  localparam int GP_PINS = 4;
  // apb map, byte addresses
  localparam logic [11:0] CFG_BASE = 12'h000;
  localparam logic [11:0] CHAIN_ADDR = 12'h100;
  localparam logic [11:0] GSRC_ADDR = 12'h104;
  localparam logic [11:0] STATE_LO_ADDR = 12'h108;
  localparam logic [11:0] STATE_HI_ADDR = 12'h10C;
  // per-element config word
  localparam int LUT_LSB = 0;
  localparam int MODE_LSB = 16;
  localparam int CLK_SEL_LSB = 18;
  localparam int CLR_SEL_LSB = 22;
  localparam int PRE_SEL_LSB = 26;
  localparam int BYP_LOCAL_BIT = 30;
  localparam int BYP_ROW_BIT = 31;
  // chain register
  localparam int LINK_LSB = 0;
  localparam int CARRY_MODE_LSB = 8;
  localparam int CARRY_INIT_LSB = 16;
  // global source register, one byte per global
  localparam int GSRC_INT_BIT = 7;
  localparam int GSRC_IDX_W = 6;
  // control source kinds in sel[3:2]
  localparam logic [1:0] SRC_DEDICATED = 2'h0;
  localparam logic [1:0] SRC_GLOBAL = 2'h1;
  localparam logic [1:0] SRC_PIN = 2'h2;
  localparam logic [1:0] SRC_INTERNAL = 2'h3;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CHAIN_RESET = 32'h0000_0000;
  localparam logic [31:0] GSRC_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} flecc_ff_mode_t;
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } flecc_le_in_t;
  typedef struct packed {
    logic local_out;
    logic row_out;
  } flecc_le_out_t;
endpackage : flecc_pkg

// ===== bench/flecc_row_asserts.sv
// apb side assertions for the logic element row
`timescale 1ns/100ps
`default_nettype none
module flecc_row_asserts
  import flecc_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_lat; psel && penable && !$past(penable) |-> !pready; endproperty
  a_lat: assert property (p_lat) else $error("ready early");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_acc; pready |-> psel && penable && $past(penable); endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_nrd; !(pready && !pwrite) |-> prdata == 32'h0000_0000; endproperty
  a_nrd: assert property (p_nrd) else $error("stray read data");
  property p_unm; pready && paddr > 12'h10F |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not refused");
  property p_map; pready && paddr < 12'h110 |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  c_err: cover property (pready && pslverr);
  c_rd: cover property (pready && !pwrite);
  c_wr: cover property (pready && pwrite);
endmodule : flecc_row_asserts
`default_nettype wire

// ===== bench/flecc_nbr.sv
// neighbouring routing feeding the element lookup inputs
`timescale 1ns/100ps
`default_nettype none
module flecc_nbr
  import flecc_pkg::*;
(
  // pattern from the bench
  input wire logic [3:0] pat,
  // element inputs
  output var flecc_le_in_t le_in [0:LES-1]
);
  // shared fan-out keeps it small; per-element patterns go untested
  always_comb begin
    for (int i = 0; i < LES; i++) begin
      le_in[i] = flecc_le_in_t'(pat);
    end
  end
endmodule : flecc_nbr
`default_nettype wire

// ===== bench/flecc_row_bench.sv
// self-checking bench for the logic element row
`timescale 1ns/100ps
`default_nettype none
module flecc_row_bench
  import flecc_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000, a;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, d;
  logic [5:0] dedicated_in = 6'h00;
  logic [3:0] gp_pin = 4'h0, pat = 4'h0;
  logic [15:0] tt;
  logic [1:0] chain_carry_out;
  flecc_le_in_t le_in [0:LES-1];
  flecc_le_out_t le_out [0:LES-1];
  logic [31:0] mdl [int];
  int fails = 0, n_checks = 0, cyc = 0, q = 0;
  flecc_row i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .dedicated_in, .gp_pin, .le_in, .le_out, .chain_carry_out);
  flecc_nbr i_nbr (.pat, .le_in);
  initial forever #50 pclk = ~pclk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // answer taken at the edge that samples pready; the hang guard ends a stuck wait
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    apb(1'h1, ad, wd);
    if (ad < STATE_LO_ADDR) mdl[ad] = wd;
  endtask : wr
  task automatic rdc(input logic [11:0] ad);
    apb(1'h0, ad, 32'h0000_0000);
    chk("prdata", mdl.exists(ad) ? mdl[ad] : 32'h0000_0000, rd);
    chk("pslverr", {31'h0000_0000, ad > 12'h10F}, {31'h0000_0000, err});
  endtask : rdc
  initial begin
    void'($urandom(80992));
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 6; i++) rdc(12'h0FC + 12'(4 * i));
    // read-only state and unmapped place
    wr(STATE_LO_ADDR, 32'hFFFF_FFFF);
    rdc(STATE_LO_ADDR);
    wr(12'h200, 32'h1234_5678);
    rdc(12'h200);
    repeat (6) begin
      // elements 0 and 1 and group 0 carry mode left alone for later tests
      a = 12'(8 + 4 * ($urandom % 64));
      d = $urandom & (a == CHAIN_ADDR ? 32'h00FF_FEFF : a == GSRC_ADDR ? 32'hBFBF_BFBF : 32'hFFFF_FFFF);
      wr(a, d);
      rdc(a);
    end
    tt = 16'($urandom);
    wr(CFG_BASE, {16'hC000, tt});
    for (int p = 0; p < 16; p++) begin
      @(posedge pclk);
      pat <= 4'(p);
      @(posedge pclk);
      @(negedge pclk);
      chk("le_out0", {30'h0000_0000, {2{tt[p]}}}, {30'h0000_0000, le_out[0]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(CFG_BASE + 12'h004, {2'h1, 8'h00, 4'h8, i < 3 ? 2'h1 : 2'h0, i < 3 ? 16'hFFFF : 16'h0000});
      q = i < 3 ? q ^ 1 : 0;
      @(posedge pclk);
      gp_pin <= 4'h1;
      @(posedge pclk);
      gp_pin <= 4'h0;
      @(posedge pclk);
      @(negedge pclk);
      chk("le_out1", {30'h0000_0000, i < 3, q[0]}, {30'h0000_0000, le_out[1]});
    end
    repeat (4) begin
      d = $urandom & 32'h00FF_00FF;
      wr(CHAIN_ADDR, d);
      q = {d[7] ? d[CARRY_INIT_LSB + 5] : d[CARRY_INIT_LSB + 7], d[3] ? d[CARRY_INIT_LSB + 1] : d[CARRY_INIT_LSB + 3]};
      @(posedge pclk);
      @(negedge pclk);
      chk("chain_carry_out", 32'(q), {30'h0000_0000, chain_carry_out});
    end
    final_report();
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      final_report();
    end
  end
endmodule : flecc_row_bench
bind flecc_row flecc_row_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr);
`default_nettype wire
